// ### src/perr_pkg.sv
/*
  shared types, register map and timing counts for the bridge parity-error
  reporting block.
  assumes: every file names its items as perr_pkg::name, nothing is imported.
*/
package perr_pkg;

  // ****************************************
  // transaction context of one data phase
  // ****************************************
  typedef enum logic [1:0] {KIND_READ, KIND_POSTED, KIND_DELAYED} kind_e;
  typedef enum logic {DIR_DOWN, DIR_UP} dir_e;

  typedef struct packed {
    logic valid;    // a data phase completed on this bus
    kind_e kind;    // read, posted write or delayed write
    dir_e dir;      // downstream or upstream
    logic bad;      // bridge's own parity check failed on this bus
    logic src_bad;  // the forwarded data already failed parity on the other bus
  } dphase_s;

  // clocks from a data phase to its parity-error report
  localparam int unsigned PERR_LAG = 2;

  // ****************************************
  // register map (byte offsets, one word each)
  // ****************************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_CLEAR = 4'h8;
  localparam logic [3:0] OFS_IRQ_EN = 4'hc;

  localparam int unsigned CTRL_W = 3;
  localparam int unsigned CTRL_PRI_RESP_BIT = 0;
  localparam int unsigned CTRL_SEC_RESP_BIT = 1;
  localparam int unsigned CTRL_SERR_EN_BIT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  localparam int unsigned STAT_W = 4;
  localparam int unsigned ST_SIG_SERR_BIT = 0;
  localparam int unsigned ST_SEC_MDP_BIT = 1;
  localparam int unsigned ST_PRI_PERR_BIT = 2;
  localparam int unsigned ST_SEC_PERR_BIT = 3;
  localparam logic [STAT_W-1:0] IRQ_EN_RESET = 4'h0;

  // ****************************************
  // helpers
  // ****************************************
  // context match on kind and direction for a completed phase
  function automatic logic is_phase(input dphase_s ph, input kind_e k, input dir_e d);
    is_phase = ph.valid && (ph.kind == k) && (ph.dir == d);
  endfunction : is_phase

  // any write kind (posted or delayed) in the given direction
  function automatic logic is_write(input dphase_s ph, input dir_e d);
    is_write = ph.valid && (ph.kind != KIND_READ) && (ph.dir == d);
  endfunction : is_write

endpackage : perr_pkg

// ### src/dphase_if.sv
/*
  carrier between the top module and its data-phase delay lines.
  assumes: one feeder and one delay line per bus, same clock.
*/
`timescale 1ns/10ps
interface dphase_if;
  perr_pkg::dphase_s in_ph;  // phase context at completion
  perr_pkg::dphase_s early;  // one clock before the report slot
  perr_pkg::dphase_s late;   // in the report slot
  modport feed (output in_ph, input early, input late);
  modport pipe (input in_ph, output early, output late);
endinterface : dphase_if

// ### src/dphase_pipe.sv
/*
  delay line carrying a data-phase context to the clock of its parity report.
  assumes: clk_i is the bus clock, rstn_i asynchronous active low.
*/
`timescale 1ns/10ps
module dphase_pipe #(
  parameter int unsigned DEPTH = perr_pkg::PERR_LAG
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  dphase_if.pipe ph
);

  // the report needs a slot before it to register the outputs
  if (DEPTH < 2) begin : g_bad_depth
    $error("dphase_pipe needs DEPTH of at least 2");
  end

  typedef struct packed {
    perr_pkg::dphase_s [DEPTH-1:0] stage;
  } pipe_s;

  pipe_s state_ff;
  pipe_s nxt_state;

  // shift the context one slot per clock
  always_comb begin
    nxt_state = state_ff;
    nxt_state.stage[0] = ph.in_ph;
    for (int i = 1; i < DEPTH; i++) begin
      nxt_state.stage[i] = state_ff.stage[i-1];
    end
  end

  // register the whole state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign ph.early = state_ff.stage[DEPTH-2];
  assign ph.late = state_ff.stage[DEPTH-1];

endmodule : dphase_pipe

// ### src/sticky_status.sv
/*
  sticky event flags with write-one-to-clear and a gated level interrupt.
  assumes: set and clear are single-clock pulses in the clk_i domain.
*/
`timescale 1ns/10ps
module sticky_status #(
  parameter int unsigned WIDTH = perr_pkg::STAT_W
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  input wire logic [WIDTH-1:0] en_i,
  output logic [WIDTH-1:0] status_o,
  output logic irq_o
);

  if (WIDTH < 1) begin : g_bad_width
    $error("sticky_status needs WIDTH of at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] flags;
    logic irq;
  } sticky_s;

  sticky_s state_ff;
  sticky_s nxt_state;

  // set wins over clear so no event is lost in the clearing clock
  always_comb begin
    nxt_state = state_ff;
    nxt_state.flags = (state_ff.flags & ~clr_i) | set_i;
    nxt_state.irq = |(nxt_state.flags & en_i);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign status_o = state_ff.flags;
  assign irq_o = state_ff.irq;

endmodule : sticky_status

// ### src/bridge_parity_error_reporting.sv
/*
  parity-error reporting of a two-port bus bridge: drives the primary and
  secondary parity-error pins and the primary system-error pin for data
  parity errors, with an avalon-mm register slave and a level interrupt.
  assumes: both buses and the register bus share clk_i; the transaction
  engine reports each completed data phase with its context as one pulse,
  and its own parity verdict on that data in the same clock.
*/
`timescale 1ns/10ps

module bridge_parity_error_reporting (
  input wire logic clk_i,
  input wire logic rstn_i,
  // register slave
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic irq_o,
  // primary bus data phase reports
  input wire logic pri_dphase_i,
  input wire perr_pkg::kind_e pri_kind_i,
  input wire perr_pkg::dir_e pri_dir_i,
  input wire logic pri_bad_i,
  input wire logic pri_src_bad_i,
  // secondary bus data phase reports
  input wire logic sec_dphase_i,
  input wire perr_pkg::kind_e sec_kind_i,
  input wire perr_pkg::dir_e sec_dir_i,
  input wire logic sec_bad_i,
  input wire logic sec_src_bad_i,
  // parity and system error pins
  input wire logic primary_parity_err_n_i,
  output logic primary_parity_err_n_o,
  output logic primary_parity_err_oe_o,
  input wire logic secondary_parity_err_n_i,
  output logic secondary_parity_err_n_o,
  output logic secondary_parity_err_oe_o,
  output logic primary_system_err_n_o,
  output logic primary_system_err_oe_o,
  output logic [perr_pkg::STAT_W-1:0] status_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [perr_pkg::CTRL_W-1:0] ctrl;
    logic [perr_pkg::STAT_W-1:0] irq_en;
    logic [31:0] rdata;
    logic wait_n;        // waitrequest: high except in the answering clock
    logic pri_drive;     // primary pin pulled low
    logic pri_park;      // primary pin driven high after a report
    logic sec_drive;
    logic sec_park;
    logic serr_drive;    // system-error pin pulled low
    logic dw_down_pend;  // secondary target reported error on a downstream delayed write
    logic dw_up_pend;    // primary target reported error on an upstream delayed write
  } top_s;

  top_s state_ff;
  top_s nxt_state;

  dphase_if pri_ph ();
  dphase_if sec_ph ();

  logic [perr_pkg::STAT_W-1:0] stat_set;
  logic [perr_pkg::STAT_W-1:0] stat_clr;
  logic [perr_pkg::STAT_W-1:0] stat_q;
  logic irq_q;

  // ****************************************
  // delay lines aligning context with the report slot
  // ****************************************
  assign pri_ph.in_ph = '{valid: pri_dphase_i, kind: pri_kind_i, dir: pri_dir_i,
                          bad: pri_bad_i, src_bad: pri_src_bad_i};
  assign sec_ph.in_ph = '{valid: sec_dphase_i, kind: sec_kind_i, dir: sec_dir_i,
                          bad: sec_bad_i, src_bad: sec_src_bad_i};

  dphase_pipe #(
    .DEPTH(perr_pkg::PERR_LAG)
  ) u_pri_pipe (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ph(pri_ph.pipe)
  );

  dphase_pipe #(
    .DEPTH(perr_pkg::PERR_LAG)
  ) u_sec_pipe (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ph(sec_ph.pipe)
  );

  // ****************************************
  // decisions
  // ****************************************
  logic pri_en;
  logic sec_en;
  logic serr_en;
  logic pri_own;
  logic sec_own;
  logic pri_fwd;
  logic sec_fwd;
  logic down_dw_seen;
  logic up_dw_seen;
  logic serr_hit;
  logic sec_mdp_hit;
  logic bus_take;
  logic byte0_wr;

  assign pri_en = state_ff.ctrl[perr_pkg::CTRL_PRI_RESP_BIT];
  assign sec_en = state_ff.ctrl[perr_pkg::CTRL_SEC_RESP_BIT];
  assign serr_en = state_ff.ctrl[perr_pkg::CTRL_SERR_EN_BIT];

  // own primary error only as write target or read initiator there
  assign pri_own = pri_ph.early.bad &&
                   (perr_pkg::is_phase(pri_ph.early, perr_pkg::KIND_READ, perr_pkg::DIR_UP) ||
                    perr_pkg::is_write(pri_ph.early, perr_pkg::DIR_DOWN));
  // forwarded report: delayed write completes on primary after secondary flagged it
  assign pri_fwd = perr_pkg::is_phase(pri_ph.early, perr_pkg::KIND_DELAYED, perr_pkg::DIR_DOWN) &&
                   (state_ff.dw_down_pend || down_dw_seen) && sec_en;

  // own secondary error only as write target or read initiator there
  assign sec_own = sec_ph.early.bad &&
                   (perr_pkg::is_phase(sec_ph.early, perr_pkg::KIND_READ, perr_pkg::DIR_DOWN) ||
                    perr_pkg::is_write(sec_ph.early, perr_pkg::DIR_UP));
  // upstream delayed write: primary target flagged it, report on secondary
  assign sec_fwd = perr_pkg::is_phase(sec_ph.early, perr_pkg::KIND_DELAYED, perr_pkg::DIR_UP) &&
                   (state_ff.dw_up_pend || up_dw_seen) && pri_en;

  // far-side target reports sampled in the report slot of a delayed write
  assign down_dw_seen = !secondary_parity_err_n_i &&
                        perr_pkg::is_phase(sec_ph.late, perr_pkg::KIND_DELAYED, perr_pkg::DIR_DOWN);
  assign up_dw_seen = !primary_parity_err_n_i &&
                      perr_pkg::is_phase(pri_ph.late, perr_pkg::KIND_DELAYED, perr_pkg::DIR_UP);

  // posted write reported bad by the destination target, not seen at intake
  assign serr_hit = serr_en && pri_en && sec_en &&
                    ((!primary_parity_err_n_i && !pri_ph.late.src_bad &&
                      perr_pkg::is_phase(pri_ph.late, perr_pkg::KIND_POSTED, perr_pkg::DIR_UP)) ||
                     (!secondary_parity_err_n_i && !sec_ph.late.src_bad &&
                      perr_pkg::is_phase(sec_ph.late, perr_pkg::KIND_POSTED, perr_pkg::DIR_DOWN)));

  // bridge mastering the secondary bus sees an error there
  assign sec_mdp_hit = sec_en && sec_ph.late.valid && (sec_ph.late.dir == perr_pkg::DIR_DOWN) &&
                       ((sec_ph.late.kind == perr_pkg::KIND_READ) ? sec_ph.late.bad
                                                                   : !secondary_parity_err_n_i);

  // request completes in the clock the slave answers
  assign bus_take = (read_i || write_i) && !state_ff.wait_n;
  assign byte0_wr = write_i && bus_take && byteenable_i[0];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_state = state_ff;

    // parity pins: pull low in the report slot, then drive high one clock; system error only pulls low, one slot later
    nxt_state.pri_drive = pri_en && (pri_own || pri_fwd);
    nxt_state.pri_park = state_ff.pri_drive;
    nxt_state.sec_drive = sec_en && (sec_own || sec_fwd);
    nxt_state.sec_park = state_ff.sec_drive;
    nxt_state.serr_drive = serr_hit;

    // pending delayed-write reports: consumed by the completion, set wins
    if (pri_fwd) begin
      nxt_state.dw_down_pend = 1'b0;
    end
    if (down_dw_seen) begin
      nxt_state.dw_down_pend = 1'b1;
    end
    if (sec_fwd) begin
      nxt_state.dw_up_pend = 1'b0;
    end
    if (up_dw_seen) begin
      nxt_state.dw_up_pend = 1'b1;
    end

    // one wait clock, then the answer clock
    nxt_state.wait_n = !((read_i || write_i) && state_ff.wait_n);

    // register writes take effect only in the answer clock
    if (byte0_wr) begin
      if (address_i == perr_pkg::OFS_CTRL) begin
        nxt_state.ctrl = writedata_i[perr_pkg::CTRL_W-1:0];
      end else if (address_i == perr_pkg::OFS_IRQ_EN) begin
        nxt_state.irq_en = writedata_i[perr_pkg::STAT_W-1:0];
      end
    end

    // read data loaded with the answer; unmapped and write-only read zero
    if (read_i && state_ff.wait_n) begin
      if (address_i == perr_pkg::OFS_CTRL) begin
        nxt_state.rdata = {{(32-perr_pkg::CTRL_W){1'b0}}, state_ff.ctrl};
      end else if (address_i == perr_pkg::OFS_STATUS) begin
        nxt_state.rdata = {{(32-perr_pkg::STAT_W){1'b0}}, stat_q};
      end else if (address_i == perr_pkg::OFS_IRQ_EN) begin
        nxt_state.rdata = {{(32-perr_pkg::STAT_W){1'b0}}, state_ff.irq_en};
      end else begin
        nxt_state.rdata = 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= '{ctrl: perr_pkg::CTRL_RESET, irq_en: perr_pkg::IRQ_EN_RESET,
                    rdata: 32'h0000_0000, wait_n: 1'b1, default: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // status flags and interrupt
  // ****************************************
  // signaled system error rises with the pin itself
  always_comb begin
    stat_set = '0;
    stat_set[perr_pkg::ST_SIG_SERR_BIT] = serr_hit;
    stat_set[perr_pkg::ST_SEC_MDP_BIT] = sec_mdp_hit;
    stat_set[perr_pkg::ST_PRI_PERR_BIT] = nxt_state.pri_drive;
    stat_set[perr_pkg::ST_SEC_PERR_BIT] = nxt_state.sec_drive;
  end

  // write-one-to-clear through the clear register
  assign stat_clr = (byte0_wr && (address_i == perr_pkg::OFS_CLEAR)) ?
                    writedata_i[perr_pkg::STAT_W-1:0] : '0;

  sticky_status #(
    .WIDTH(perr_pkg::STAT_W)
  ) u_status (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .set_i(stat_set),
    .clr_i(stat_clr),
    .en_i(state_ff.irq_en),
    .status_o(stat_q),
    .irq_o(irq_q)
  );

  // ****************************************
  // outputs, all from flops
  // ****************************************
  assign readdata_o = state_ff.rdata;
  assign waitrequest_o = state_ff.wait_n;
  assign irq_o = irq_q;
  assign status_o = stat_q;
  assign primary_parity_err_n_o = !state_ff.pri_drive;
  assign primary_parity_err_oe_o = state_ff.pri_drive || state_ff.pri_park;
  assign secondary_parity_err_n_o = !state_ff.sec_drive;
  assign secondary_parity_err_oe_o = state_ff.sec_drive || state_ff.sec_park;
  // open-drain: only ever pulls low, never drives high
  assign primary_system_err_n_o = !state_ff.serr_drive;
  assign primary_system_err_oe_o = state_ff.serr_drive;

endmodule : bridge_parity_error_reporting

// ### verification/bridge_parity_error_reporting_checker.sv
/*
  assertion checker of the parity-error reporting block.
  assumes: bound to the top module, one clock, enables not rewritten mid-transfer.
*/
`timescale 1ns/10ps
module perr_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] address_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  input wire logic waitrequest_o,
  input wire logic pri_dphase_i,
  input wire perr_pkg::kind_e pri_kind_i,
  input wire perr_pkg::dir_e pri_dir_i,
  input wire logic pri_bad_i,
  input wire logic sec_dphase_i,
  input wire perr_pkg::kind_e sec_kind_i,
  input wire perr_pkg::dir_e sec_dir_i,
  input wire logic sec_bad_i,
  input wire logic sec_src_bad_i,
  input wire logic primary_parity_err_n_o,
  input wire logic primary_parity_err_oe_o,
  input wire logic secondary_parity_err_n_i,
  input wire logic secondary_parity_err_n_o,
  input wire logic secondary_parity_err_oe_o,
  input wire logic primary_system_err_n_o,
  input wire logic primary_system_err_oe_o,
  input wire logic [perr_pkg::STAT_W-1:0] status_o
);
  // ****************************************
  // helper logic
  // ****************************************
  logic [2:0] ctrl_ff;
  logic [2:0] nxt_ctrl;
  logic pri_en, sec_en, serr_en, p_role, s_role, p_low, s_low;

  // shadow of the control word, taken only at the accepting edge
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (write_i && !waitrequest_o && address_i == perr_pkg::OFS_CTRL && byteenable_i[0]) begin
      nxt_ctrl = writedata_i[2:0];
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_ff <= 3'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // write target or read initiator on each bus
  assign {serr_en, sec_en, pri_en} = ctrl_ff;
  assign p_role = pri_dphase_i && ((pri_kind_i == perr_pkg::KIND_READ) == (pri_dir_i == perr_pkg::DIR_UP));
  assign s_role = sec_dphase_i && ((sec_kind_i == perr_pkg::KIND_READ) == (sec_dir_i == perr_pkg::DIR_DOWN));
  assign p_low = primary_parity_err_oe_o && !primary_parity_err_n_o;
  assign s_low = secondary_parity_err_oe_o && !secondary_parity_err_n_o;

  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_pri_own; p_role && pri_bad_i && pri_en |-> ##2 p_low; endproperty
  a_pri_own: assert property (p_pri_own) else $error("primary pin missed own error");
  property p_pri_role; p_low |-> $past(p_role, 2); endproperty
  a_pri_role: assert property (p_pri_role) else $error("primary pin low outside its role");
  property p_pri_en; p_low |-> $past(pri_en, 2); endproperty
  a_pri_en: assert property (p_pri_en) else $error("primary pin low while disabled");
  property p_sec_own; s_role && sec_bad_i && sec_en |-> ##2 s_low; endproperty
  a_sec_own: assert property (p_sec_own) else $error("secondary pin missed own error");
  property p_sec_role; s_low |-> $past(s_role, 2); endproperty
  a_sec_role: assert property (p_sec_role) else $error("secondary pin low outside its role");
  property p_sec_en; s_low |-> $past(sec_en, 2); endproperty
  a_sec_en: assert property (p_sec_en) else $error("secondary pin low while disabled");
  property p_serr_cause;
    sec_dphase_i && sec_kind_i == perr_pkg::KIND_POSTED && sec_dir_i == perr_pkg::DIR_DOWN && !sec_src_bad_i
      && (&ctrl_ff) ##2 !secondary_parity_err_n_i |=> !primary_system_err_n_o && primary_system_err_oe_o;
  endproperty
  a_serr_cause: assert property (p_serr_cause) else $error("system error missing");
  property p_serr_gate; !primary_system_err_n_o |-> $past(serr_en) && $past(pri_en) && $past(sec_en); endproperty
  a_serr_gate: assert property (p_serr_gate) else $error("system error while gated");
  property p_serr_flag; !primary_system_err_n_o |-> status_o[perr_pkg::ST_SIG_SERR_BIT]; endproperty
  a_serr_flag: assert property (p_serr_flag) else $error("system error without status");

  c_pri: cover property (p_role && pri_bad_i ##2 p_low);
  c_sec: cover property (s_role && sec_bad_i ##2 s_low);
  c_serr: cover property (!primary_system_err_n_o);
endmodule : perr_checker

bind bridge_parity_error_reporting perr_checker i_perr_checker (
  .clk_i(clk_i), .rstn_i(rstn_i), .address_i(address_i), .write_i(write_i), .writedata_i(writedata_i),
  .byteenable_i(byteenable_i), .waitrequest_o(waitrequest_o), .pri_dphase_i(pri_dphase_i),
  .pri_kind_i(pri_kind_i), .pri_dir_i(pri_dir_i), .pri_bad_i(pri_bad_i), .sec_dphase_i(sec_dphase_i),
  .sec_kind_i(sec_kind_i), .sec_dir_i(sec_dir_i), .sec_bad_i(sec_bad_i), .sec_src_bad_i(sec_src_bad_i),
  .primary_parity_err_n_o(primary_parity_err_n_o), .primary_parity_err_oe_o(primary_parity_err_oe_o),
  .secondary_parity_err_n_i(secondary_parity_err_n_i), .secondary_parity_err_n_o(secondary_parity_err_n_o),
  .secondary_parity_err_oe_o(secondary_parity_err_oe_o), .primary_system_err_n_o(primary_system_err_n_o),
  .primary_system_err_oe_o(primary_system_err_oe_o), .status_o(status_o));

// ### verification/far_bus_model.sv
/*
  far-side agents of both buses: targets that report parity on command.
  assumes: commands change just after a rising edge; both lines pulled up.
*/
`timescale 1ns/10ps
module far_bus_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic pri_report_i,
  input wire logic sec_report_i,
  input wire logic pri_n_i,
  input wire logic pri_oe_i,
  input wire logic sec_n_i,
  input wire logic sec_oe_i,
  output logic pri_line_o,
  output logic sec_line_o
);
  logic [1:0] drive_ff;

  // report lands in the slot two clocks after the data phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drive_ff <= 2'h0;
    end else begin
      drive_ff <= {sec_report_i, pri_report_i};
    end
  end

  // wired low with pull-up, so a released line reads high
  assign pri_line_o = !(drive_ff[0] || (pri_oe_i && !pri_n_i));
  assign sec_line_o = !(drive_ff[1] || (sec_oe_i && !sec_n_i));
endmodule : far_bus_model

// ### verification/bridge_parity_error_reporting_test.sv
/*
  self-checking bench of the parity-error reporting block.
  assumes: package, design, checker and far-side model compiled before it.
*/
`timescale 1ns/10ps
module bridge_parity_error_reporting_test;
  logic clk_i, rstn_i, read_i, write_i, pri_rep, sec_rep, pri_line, sec_line, irq_o, waitrequest_o;
  logic p_n, p_oe, s_n, s_oe, serr_n, serr_oe, s, b;
  logic [2:0] en;
  logic [3:0] address_i;
  logic [31:0] writedata_i, readdata_o, q;
  logic [perr_pkg::STAT_W-1:0] status_o;
  perr_pkg::dphase_s pri_ph, sec_ph;
  perr_pkg::kind_e k;
  perr_pkg::dir_e d;
  int fail_count, num_checks, i, seed;

  bridge_parity_error_reporting i_bridge_parity_error_reporting (
    .clk_i(clk_i), .rstn_i(rstn_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(4'hf), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .irq_o(irq_o), .pri_dphase_i(pri_ph.valid), .pri_kind_i(pri_ph.kind), .pri_dir_i(pri_ph.dir),
    .pri_bad_i(pri_ph.bad), .pri_src_bad_i(pri_ph.src_bad), .sec_dphase_i(sec_ph.valid),
    .sec_kind_i(sec_ph.kind), .sec_dir_i(sec_ph.dir), .sec_bad_i(sec_ph.bad), .sec_src_bad_i(sec_ph.src_bad),
    .primary_parity_err_n_i(pri_line), .primary_parity_err_n_o(p_n), .primary_parity_err_oe_o(p_oe),
    .secondary_parity_err_n_i(sec_line), .secondary_parity_err_n_o(s_n), .secondary_parity_err_oe_o(s_oe),
    .primary_system_err_n_o(serr_n), .primary_system_err_oe_o(serr_oe), .status_o(status_o));

  far_bus_model i_far_bus_model (
    .clk_i(clk_i), .rstn_i(rstn_i), .pri_report_i(pri_rep), .sec_report_i(sec_rep), .pri_n_i(p_n),
    .pri_oe_i(p_oe), .sec_n_i(s_n), .sec_oe_i(s_oe), .pri_line_o(pri_line), .sec_line_o(sec_line));

  // ****************************************
  // expectations and shared tasks
  // ****************************************
  function automatic logic exp_pri(input logic sb, input perr_pkg::kind_e kk, input perr_pkg::dir_e dd,
      input logic [2:0] ee);
    return !sb && ee[0] && ((kk == perr_pkg::KIND_READ) == (dd == perr_pkg::DIR_UP));
  endfunction : exp_pri

  function automatic logic exp_sec(input logic sb, input perr_pkg::kind_e kk, input perr_pkg::dir_e dd,
      input logic [2:0] ee);
    return sb && ee[1] && ((kk == perr_pkg::KIND_READ) == (dd == perr_pkg::DIR_DOWN));
  endfunction : exp_sec

  task automatic end_of_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one avalon transfer; the idle edge first keeps back-to-back calls apart
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (!waitrequest_o) break;
    end
    if (n == 20) begin
      fail_count++;
      end_of_test();
    end
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask : bus

  // one data phase, optional far report, then pins in slot 2 and system error in slot 3
  task automatic phase(input logic sb, input perr_pkg::kind_e kk, input perr_pkg::dir_e dd, input logic bad,
      input logic src, input logic far, input logic ep, input logic es, input logic ev);
    perr_pkg::dphase_s ph, idle;
    ph = '{1'b1, kk, dd, bad, src};
    idle = '0;
    @(posedge clk_i);
    pri_ph <= sb ? idle : ph;
    sec_ph <= sb ? ph : idle;
    @(posedge clk_i);
    pri_ph <= idle;
    sec_ph <= idle;
    pri_rep <= far && !sb;
    sec_rep <= far && sb;
    @(posedge clk_i);
    pri_rep <= 1'b0;
    sec_rep <= 1'b0;
    @(negedge clk_i);
    check({30'h0, p_oe && !p_n, s_oe && !s_n}, {30'h0, ep, es});
    @(negedge clk_i);
    check({31'h0, serr_oe && !serr_n}, {31'h0, ev});
  endtask : phase

  // ****************************************
  // clock and main sequence
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    {rstn_i, read_i, write_i, pri_rep, sec_rep} = 5'h0;
    address_i = 4'h0;
    writedata_i = 32'h0;
    pri_ph = '0;
    sec_ph = '0;
    seed = $urandom(26);
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    check({p_oe, s_oe, serr_oe, irq_o, waitrequest_o, status_o}, {5'h1, 4'h0});
    bus(1'b1, perr_pkg::OFS_CTRL, 32'h5, q);
    bus(1'b0, perr_pkg::OFS_CTRL, 32'h0, q);
    check(q, 32'h5);
    bus(1'b0, 4'h2, 32'h0, q);
    check(q, 32'h0);
    // every kind, direction and bus, first with all enables, then at random
    for (i = 0; i < 60; i++) begin
      en = (i < 12) ? 3'h7 : 3'($urandom_range(0, 7));
      b = (i < 12) ? 1'b1 : 1'($urandom_range(0, 1));
      k = perr_pkg::kind_e'(i % 3);
      d = perr_pkg::dir_e'((i / 3) % 2);
      s = ((i / 6) % 2) == 1;
      bus(1'b1, perr_pkg::OFS_CTRL, {29'h0, en}, q);
      phase(s, k, d, b, 1'b0, 1'b0, b && exp_pri(s, k, d, en), b && exp_sec(s, k, d, en), 1'b0);
    end
    // far reports on posted and delayed writes
    bus(1'b1, perr_pkg::OFS_CTRL, 32'h7, q);
    phase(1'b1, perr_pkg::KIND_POSTED, perr_pkg::DIR_DOWN, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    phase(1'b0, perr_pkg::KIND_POSTED, perr_pkg::DIR_UP, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    phase(1'b1, perr_pkg::KIND_POSTED, perr_pkg::DIR_DOWN, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    phase(1'b1, perr_pkg::KIND_DELAYED, perr_pkg::DIR_DOWN, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    phase(1'b0, perr_pkg::KIND_DELAYED, perr_pkg::DIR_DOWN, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    phase(1'b0, perr_pkg::KIND_DELAYED, perr_pkg::DIR_UP, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    phase(1'b1, perr_pkg::KIND_DELAYED, perr_pkg::DIR_UP, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    for (i = 3; i < 7; i++) begin
      bus(1'b1, perr_pkg::OFS_CTRL, 32'(i), q);
      phase(1'b1, perr_pkg::KIND_POSTED, perr_pkg::DIR_DOWN, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    end
    // status, masked and unmasked interrupt, then clear
    bus(1'b0, perr_pkg::OFS_STATUS, 32'h0, q);
    check(q & 32'h1, 32'h1);
    check({31'h0, irq_o}, 32'h0);
    bus(1'b1, perr_pkg::OFS_IRQ_EN, 32'h1, q);
    bus(1'b0, perr_pkg::OFS_IRQ_EN, 32'h0, q);
    check(q, 32'h1);
    check({31'h0, irq_o}, 32'h1);
    bus(1'b1, perr_pkg::OFS_CLEAR, 32'hf, q);
    bus(1'b0, perr_pkg::OFS_STATUS, 32'h0, q);
    check(q, 32'h0);
    check({31'h0, irq_o}, 32'h0);
    end_of_test();
  end
endmodule : bridge_parity_error_reporting_test
